// ===== fic_pkg.sv
// shared constants and types for the fpu/tcm interrupt combiner
package fic_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00; // enables and fpu flags
  localparam logic [7:0] STAT_OFF = 8'h04; // sticky event status
  localparam logic [7:0] MASK_OFF = 8'h08; // event interrupt mask
  // fields of irq_status_control_reg
  localparam int DENORMAL_POS = 0;
  localparam int INEXACT_POS = 1;
  localparam int UNDERFLOW_POS = 2;
  localparam int OVERFLOW_POS = 3;
  localparam int DIV_ZERO_POS = 4;
  localparam int INVALID_OP_POS = 5;
  localparam int WRITE_ABORT_POS = 6;
  localparam int NUM_FPU = 6;
  localparam int ENABLE_BASE = 8; // enables at [14:8]
  localparam int ABORT_STAT_POS = 16;
  localparam int ABORT_OVR_POS = 17;
  localparam int NUM_EVT = 7;
  // interrupt identity
  localparam int IRQ_VECTOR = 54;
  localparam int IRQ_LINE = 9;
  localparam int FAULT_INDEX = 2;
  // reset values
  localparam logic [6:0] ENABLE_RST = 7'h00;
  localparam logic [6:0] MASK_RST = 7'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {FIC_IDLE, FIC_RESP} fic_bus_state_t;
endpackage

// ===== fic_evt_flags.sv
// sticky event flags with set-over-clear and read clear
`timescale 1ns/1ps
module fic_evt_flags (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [6:0] set_in,
  input wire logic clear_in,
  output logic [6:0] flags_out
);
  typedef struct packed {
    logic [6:0] flags_reg;
  } fic_flags_state_t;
  fic_flags_state_t s_reg;
  fic_flags_state_t s_next;
  // set wins over clear per bit
  always_comb
  begin
    s_next = s_reg;
    for (int i = 0; i < fic_pkg::NUM_EVT; i++)
    begin
      if (set_in[i])
        s_next.flags_reg[i] = 1'b1;
      else if (clear_in)
        s_next.flags_reg[i] = 1'b0;
    end
  end
  // register
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end
  assign flags_out = s_reg.flags_reg;
endmodule

// ===== fic_write_abort.sv
// write abort detector with status and overrun flags
`timescale 1ns/1ps
module fic_write_abort (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic wr_done_in,
  input wire logic ecc_uncorr_in,
  input wire logic clear_in,
  output logic abort_pulse_out,
  output logic status_out,
  output logic overrun_out
);
  typedef struct packed {
    logic status_reg;
    logic overrun_reg;
  } fic_wab_state_t;
  fic_wab_state_t s_reg;
  fic_wab_state_t s_next;
  logic abort;
  assign abort = wr_done_in & ecc_uncorr_in;
  assign abort_pulse_out = abort;
  // status and overrun; new abort beats clear
  always_comb
  begin
    s_next = s_reg;
    if (clear_in)
    begin
      s_next.status_reg = 1'b0;
      s_next.overrun_reg = 1'b0;
    end
    if (abort)
    begin
      s_next.status_reg = 1'b1;
      if (s_reg.status_reg && !clear_in)
        s_next.overrun_reg = 1'b1;
    end
  end
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end
  assign status_out = s_reg.status_reg;
  assign overrun_out = s_reg.overrun_reg;
endmodule

// ===== fic_irq_combiner.sv
// fpu and tcm write abort interrupt combiner with axi4-lite registers
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - one combined interrupt request line, vector 54, controller line 9
// - denormal enable and denormal flag raise the interrupt
// - inexact enable and inexact flag raise the interrupt
// - underflow enable and underflow flag raise the interrupt
// - overflow enable and overflow flag raise the interrupt
// - divide-by-zero enable and flag raise the interrupt
// - invalid-operation enable and flag raise the interrupt
// - every write abort raises interrupt while its enable set, none missed
// - tcm write through core slave port with uncorrectable ecc is abort
// - each write abort also reported as noncritical fault 2
// - both write-abort status flags cleared by functional reset
module fic_irq_combiner (
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [5:0] FPU_FLAGS_IN,
  input wire logic TCM_WR_DONE_IN,
  input wire logic TCM_ECC_UNCORR_IN,
  input wire logic [7:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic [7:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  output logic COMBINED_IRQ_OUT,
  output logic EVENT_IRQ_OUT,
  output logic NONCRITICAL_FAULT_OUT
);
  typedef struct packed {
    logic [6:0] enable_reg;
    logic [6:0] mask_reg;
    logic aw_got_reg;
    logic w_got_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic fault_reg;
    logic irq_reg;
    logic evt_irq_reg;
  } fic_state_t;
  fic_state_t s_reg;
  fic_state_t s_next;
  logic abort_pulse;
  logic wab_status;
  logic wab_overrun;
  logic wab_clear;
  logic stat_clear;
  logic [6:0] evt_flags;
  logic [6:0] src_flags;
  logic [6:0] evt_set;
  logic wr_fire;
  logic rd_fire;
  logic [31:0] ctrl_view;
  logic [6:0] src_hit;
  // write abort tracking
  fic_write_abort u_wab (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RST_N_IN),
    .wr_done_in(TCM_WR_DONE_IN),
    .ecc_uncorr_in(TCM_ECC_UNCORR_IN),
    .clear_in(wab_clear),
    .abort_pulse_out(abort_pulse),
    .status_out(wab_status),
    .overrun_out(wab_overrun)
  );
  // sticky event status for the masked event line
  fic_evt_flags u_evt (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RST_N_IN),
    .set_in(evt_set),
    .clear_in(stat_clear),
    .flags_out(evt_flags)
  );
  // source flags; abort term uses live pulse too so no event is missed
  assign src_flags = {wab_status | abort_pulse, FPU_FLAGS_IN};
  assign evt_set = {abort_pulse, FPU_FLAGS_IN};
  generate
    for (genvar g = 0; g < fic_pkg::NUM_EVT; g++)
    begin : g_src
      assign src_hit[g] = s_reg.enable_reg[g] & src_flags[g];
    end
  endgenerate
  // bus handshakes
  assign wr_fire = s_reg.aw_got_reg && s_reg.w_got_reg && !s_reg.bvalid_reg;
  assign rd_fire = S_AXI_ARVALID_IN && !s_reg.rvalid_reg;
  assign S_AXI_AWREADY_OUT = !s_reg.aw_got_reg && !s_reg.bvalid_reg;
  assign S_AXI_WREADY_OUT = !s_reg.w_got_reg && !s_reg.bvalid_reg;
  assign S_AXI_ARREADY_OUT = !s_reg.rvalid_reg;
  assign stat_clear = rd_fire && (S_AXI_ARADDR_IN == fic_pkg::STAT_OFF);
  // write-one-to-clear of abort status bits in control register
  assign wab_clear = wr_fire && (s_reg.awaddr_reg == fic_pkg::CTRL_OFF) && s_reg.wstrb_reg[2]
    && (s_reg.wdata_reg[fic_pkg::ABORT_STAT_POS] || s_reg.wdata_reg[fic_pkg::ABORT_OVR_POS]);
  // control register view
  always_comb
  begin
    ctrl_view = 32'h0000_0000;
    ctrl_view[5:0] = FPU_FLAGS_IN;
    ctrl_view[fic_pkg::WRITE_ABORT_POS] = wab_status;
    ctrl_view[14:8] = s_reg.enable_reg;
    ctrl_view[fic_pkg::ABORT_STAT_POS] = wab_status;
    ctrl_view[fic_pkg::ABORT_OVR_POS] = wab_overrun;
  end
  // next state
  always_comb
  begin
    s_next = s_reg;
    if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT)
    begin
      s_next.aw_got_reg = 1'b1;
      s_next.awaddr_reg = S_AXI_AWADDR_IN;
    end
    if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT)
    begin
      s_next.w_got_reg = 1'b1;
      s_next.wdata_reg = S_AXI_WDATA_IN;
      s_next.wstrb_reg = S_AXI_WSTRB_IN;
    end
    // register write
    if (wr_fire)
    begin
      s_next.aw_got_reg = 1'b0;
      s_next.w_got_reg = 1'b0;
      s_next.bvalid_reg = 1'b1;
      s_next.bresp_reg = fic_pkg::RESP_OKAY;
      case (s_reg.awaddr_reg)
        fic_pkg::CTRL_OFF:
        begin
          if (s_reg.wstrb_reg[1])
            s_next.enable_reg = s_reg.wdata_reg[14:8];
        end
        fic_pkg::MASK_OFF:
        begin
          if (s_reg.wstrb_reg[0])
            s_next.mask_reg = s_reg.wdata_reg[6:0];
        end
        fic_pkg::STAT_OFF:
          s_next.bresp_reg = fic_pkg::RESP_OKAY;
        default:
          s_next.bresp_reg = fic_pkg::RESP_SLVERR;
      endcase
    end
    if (s_reg.bvalid_reg && S_AXI_BREADY_IN)
      s_next.bvalid_reg = 1'b0;
    // register read
    if (rd_fire)
    begin
      s_next.rvalid_reg = 1'b1;
      s_next.rresp_reg = fic_pkg::RESP_OKAY;
      case (S_AXI_ARADDR_IN)
        fic_pkg::CTRL_OFF:
          s_next.rdata_reg = ctrl_view;
        fic_pkg::STAT_OFF:
          s_next.rdata_reg = {25'h0000000, evt_flags};
        fic_pkg::MASK_OFF:
          s_next.rdata_reg = {25'h0000000, s_reg.mask_reg};
        default:
        begin
          s_next.rdata_reg = 32'h0000_0000;
          s_next.rresp_reg = fic_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_reg.rvalid_reg && S_AXI_RREADY_IN)
      s_next.rvalid_reg = 1'b0;
    s_next.irq_reg = |src_hit;
    // abort enable term included above via live pulse and status
    s_next.evt_irq_reg = |(s_reg.mask_reg & evt_flags);
    s_next.fault_reg = abort_pulse;
  end
  // state register, reset clears all
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      s_reg <= '0;
      s_reg.enable_reg <= fic_pkg::ENABLE_RST;
      s_reg.mask_reg <= fic_pkg::MASK_RST;
    end
    else
      s_reg <= s_next;
  end
  assign S_AXI_BVALID_OUT = s_reg.bvalid_reg;
  assign S_AXI_BRESP_OUT = s_reg.bresp_reg;
  assign S_AXI_RVALID_OUT = s_reg.rvalid_reg;
  assign S_AXI_RDATA_OUT = s_reg.rdata_reg;
  assign S_AXI_RRESP_OUT = s_reg.rresp_reg;
  assign COMBINED_IRQ_OUT = s_reg.irq_reg;
  assign EVENT_IRQ_OUT = s_reg.evt_irq_reg;
  assign NONCRITICAL_FAULT_OUT = s_reg.fault_reg;
endmodule

// ===== fic_irq_combiner_asserts.sv
// concurrent checks on the combiner ports
`timescale 1ns/1ps
module fic_irq_combiner_asserts (
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic TCM_WR_DONE_IN,
  input wire logic TCM_ECC_UNCORR_IN,
  input wire logic S_AXI_ARVALID_IN,
  input wire logic S_AXI_ARREADY_OUT,
  input wire logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  input wire logic COMBINED_IRQ_OUT,
  input wire logic EVENT_IRQ_OUT,
  input wire logic NONCRITICAL_FAULT_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // abort, and a lone abort with none after it
  sequence s_abort;
    TCM_WR_DONE_IN && TCM_ECC_UNCORR_IN;
  endsequence
  sequence s_lone;
    s_abort ##1 !(TCM_WR_DONE_IN && TCM_ECC_UNCORR_IN);
  endsequence
  AST_FAULT_PULSE: assert property (s_abort |=> NONCRITICAL_FAULT_OUT)
    else $error("no fault pulse after abort");
  AST_FAULT_CAUSE: assert property (NONCRITICAL_FAULT_OUT |-> $past(TCM_WR_DONE_IN && TCM_ECC_UNCORR_IN))
    else $error("fault pulse without abort");
  AST_FAULT_ONE: assert property (s_lone |=> !NONCRITICAL_FAULT_OUT)
    else $error("fault pulse too long");
  AST_RST_QUIET: assert property (@(posedge SYS_CLK_IN) disable iff (1'b0) !RST_N_IN |=>
    !COMBINED_IRQ_OUT && !EVENT_IRQ_OUT && !NONCRITICAL_FAULT_OUT)
    else $error("outputs active after reset");
  AST_B_DROP: assert property (S_AXI_BVALID_OUT && S_AXI_BREADY_IN |=> !S_AXI_BVALID_OUT)
    else $error("write response repeated");
  AST_R_DROP: assert property (S_AXI_RVALID_OUT && S_AXI_RREADY_IN |=> !S_AXI_RVALID_OUT)
    else $error("read response repeated");
  AST_R_SOON: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT)
    else $error("read answer late");
  AST_AR_BLOCK: assert property (S_AXI_RVALID_OUT |-> !S_AXI_ARREADY_OUT)
    else $error("read taken while answer pending");
endmodule
bind fic_irq_combiner fic_irq_combiner_asserts u_fic_irq_combiner_asserts (.*);

// ===== fic_core_model.sv
// core model: fpu exception levels and tcm slave-port writes
`timescale 1ns/1ps
module fic_core_model (
  input wire logic clk_in,
  output logic [5:0] fpu_flags_out,
  output logic wr_done_out,
  output logic ecc_uncorr_out
);
  // idle core
  initial
  begin
    fpu_flags_out = 6'h00;
    wr_done_out = 1'b0;
    ecc_uncorr_out = 1'b1;
  end
  // fpu holds its exception levels
  task automatic fpu(input logic [5:0] f);
    @(posedge clk_in);
    fpu_flags_out <= f;
  endtask
  task automatic tcm_write(input logic bad, input int gap);
    repeat (gap) @(posedge clk_in);
    @(posedge clk_in);
    wr_done_out <= 1'b1;
    ecc_uncorr_out <= bad;
    @(posedge clk_in);
    wr_done_out <= 1'b0;
    ecc_uncorr_out <= ~bad; // qualifier meaningless outside a write
  endtask
endmodule

// ===== fic_irq_combiner_bench.sv
// self-checking bench for the interrupt combiner
`timescale 1ns/1ps
`define CHK(g, e) \
  begin checks++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module fic_irq_combiner_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] ad = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [3:0] ws = 4'h0;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic awr, wr, bv, arr, rv, irq, evt, flt, done, ecc;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdat, q;
  logic [5:0] ff;
  int n_errors = 0, checks = 0, cyc = 0, flt_n = 0;
  fic_core_model u_fic_core_model (.clk_in(clk), .fpu_flags_out(ff), .wr_done_out(done), .ecc_uncorr_out(ecc));
  fic_irq_combiner u_fic_irq_combiner (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .FPU_FLAGS_IN(ff),
    .TCM_WR_DONE_IN(done), .TCM_ECC_UNCORR_IN(ecc), .S_AXI_AWADDR_IN(ad), .S_AXI_AWVALID_IN(awv),
    .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(ws), .S_AXI_WVALID_IN(wv),
    .S_AXI_WREADY_OUT(wr), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(br),
    .S_AXI_ARADDR_IN(ad), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rdat),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rr), .COMBINED_IRQ_OUT(irq),
    .EVENT_IRQ_OUT(evt), .NONCRITICAL_FAULT_OUT(flt));
  // clock
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  // cycle limit and fault pulse count
  always @(posedge clk)
  begin
    cyc++;
    if (flt)
      flt_n++;
    if (cyc == 20000)
    begin
      n_errors++;
      wrap_up;
    end
  end
  task automatic wrap_up;
    if (n_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // one axi4-lite write (w high) or read, waits for the answer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    ad <= a;
    wd <= d;
    ws <= s;
    awv <= w;
    wv <= w;
    br <= w;
    arv <= !w;
    rr <= !w;
    do
    begin
      @(posedge clk);
      if (awr)
        awv <= 1'b0;
      if (wr)
        wv <= 1'b0;
      if (arr)
        arv <= 1'b0;
    end while (!(w ? bv : rv));
    r = w ? bresp : rresp;
    q = rdat;
    br <= 1'b0;
    rr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0, 4'h0);
  endtask
  task automatic wrt(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    bus(1'b1, a, d, s);
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
  endtask
  // reset values and an unmapped place
  task automatic t_regs;
    rd(8'h00);
    `CHK(q, 32'h0)
    rd(8'h08);
    `CHK(q, 32'h0)
    rd(8'h0c);
    `CHK(r, fic_pkg::RESP_SLVERR)
    `CHK(q, 32'h0)
    wrt(8'h0c, 32'hffff_ffff, 4'hf);
    `CHK(r, fic_pkg::RESP_SLVERR)
  endtask
  // each fpu source gated by its own enable, level behaviour
  task automatic t_fpu;
    for (int i = 0; i < 6; i++)
    begin
      wrt(8'h00, 32'h1 << (8 + i), 4'h2);
      u_fic_core_model.fpu(6'h3f ^ (6'h01 << i));
      settle;
      `CHK(irq, 1'b0)
      u_fic_core_model.fpu(6'h01 << i);
      settle;
      `CHK(irq, 1'b1)
      settle;
      `CHK(irq, 1'b1)
      u_fic_core_model.fpu(6'h00);
      settle;
      `CHK(irq, 1'b0)
    end
  endtask
  // clean write, two aborts back to back, status and clear
  task automatic t_abort;
    rd(8'h04);
    wrt(8'h00, 32'h0000_4000, 4'h2);
    wrt(8'h08, 32'h0000_0040, 4'h1);
    u_fic_core_model.tcm_write(1'b0, 0);
    settle;
    `CHK(irq, 1'b0)
    `CHK(flt_n, 0)
    u_fic_core_model.tcm_write(1'b1, 0);
    u_fic_core_model.tcm_write(1'b1, 0);
    settle;
    `CHK(irq, 1'b1)
    `CHK(evt, 1'b1)
    `CHK(flt_n, 2)
    rd(8'h00);
    `CHK(q, 32'h0003_4040)
    rd(8'h04);
    `CHK(q, 32'h0000_0040)
    rd(8'h04);
    `CHK(q, 32'h0)
    `CHK(evt, 1'b0)
    wrt(8'h00, 32'h0001_4000, 4'h6);
    settle;
    `CHK(irq, 1'b0)
  endtask
  // abort handled elsewhere, then a functional reset
  task automatic t_soft;
    wrt(8'h00, 32'h0, 4'h2);
    u_fic_core_model.tcm_write(1'b1, 2);
    settle;
    `CHK(irq, 1'b0)
    `CHK(flt_n, 3)
    rd(8'h00);
    `CHK(q, 32'h0001_0040)
    rst_n <= 1'b0;
    settle;
    rst_n <= 1'b1;
    rd(8'h00);
    `CHK(q, 32'h0)
  endtask
  // main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_fpu;
    t_abort;
    t_soft;
    wrap_up;
  end
endmodule
